// ===== hdl/ssp_regs.vh
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
// ---------------------------------------------------------------
// Register byte addresses.
// ---------------------------------------------------------------
`define SSP_ADDR_MODE 12'h000
`define SSP_ADDR_FMT 12'h004
`define SSP_ADDR_DATA 12'h008
`define SSP_ADDR_IRQ_STAT 12'h00c
`define SSP_ADDR_IRQ_MASK 12'h010
// ---------------------------------------------------------------
// Mode control fields and reset value.
// ---------------------------------------------------------------
`define SSP_MODE_RST 8'he0
`define SSP_MODE_FLD_HI 7
`define SSP_MODE_FLD_LO 5
`define SSP_UART_BIT 4
`define SSP_EN_BIT 1
`define SSP_INCF_BIT 0
`define SSP_M_DIV4 3'h0
`define SSP_M_DIV16 3'h1
`define SSP_M_DIV64 3'h2
`define SSP_M_SUB 3'h3
`define SSP_M_TMR 3'h4
`define SSP_M_SLAVE 3'h5
// ---------------------------------------------------------------
// Format control fields and reset value.
// ---------------------------------------------------------------
`define SSP_FMT_RST 8'h00
`define SSP_POL_BIT 5
`define SSP_EDGE_BIT 4
`define SSP_ORDER_BIT 3
`define SSP_SELECT_PIN_ENABLE_BIT 2
`define SSP_WRITE_COLLISION_FLAG_BIT 1
`define SSP_TRF_BIT 0
// ---------------------------------------------------------------
// Half periods of the serial clock in system clocks, less one, and the bits per frame.
// ---------------------------------------------------------------
`define SSP_HALF_DIV4 8'h01
`define SSP_HALF_DIV16 8'h07
`define SSP_HALF_DIV64 8'h1f
`define SSP_BITS 4'h8
`endif

// ===== hdl/ssp_shifter.v
module ssp_shifter #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire load_i,
  input wire [WIDTH-1:0] load_data_i,
  input wire sample_i,
  input wire shift_i,
  input wire msb_first_i,
  input wire sdi_i,
  output reg [WIDTH-1:0] data_o,
  output reg sdo_o
);
  reg rx_bit_r;
  always @(posedge clk_i) begin
    if (reset_i) begin
      data_o <= {WIDTH{1'b0}};
      sdo_o <= 1'b0;
      rx_bit_r <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        data_o <= load_data_i;
        sdo_o <= msb_first_i ? load_data_i[WIDTH-1] : load_data_i[0];
      end else begin
        if (sample_i) begin
          rx_bit_r <= sdi_i;
        end
        if (shift_i) begin
          if (msb_first_i) begin
            data_o <= {data_o[WIDTH-2:0], rx_bit_r};
            sdo_o <= data_o[WIDTH-2];
          end else begin
            data_o <= {rx_bit_r, data_o[WIDTH-1:1]};
            sdo_o <= data_o[1];
          end
        end
      end
    end
  end
endmodule

// ===== hdl/ssp_top.v
// The APB interface to the registers and the address map were left to the implementer.
`include "ssp_regs.vh"
module ssp_top #(
  parameter HALF_WIDTH = 8
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire sub_tick_i,
  input wire tmr_match_i,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  input wire sdi_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  input wire slave_select_n_i,
  output reg slave_select_n_o,
  output reg slave_select_n_oe_o,
  output reg irq_o
);
  // ---------------------------------------------------------------
  // Registers and decode.
  // ---------------------------------------------------------------
  reg [7:0] serial_mode_control_r;
  reg [7:0] serial_format_control_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg busy_r;
  reg [3:0] bit_cnt_r;
  reg [HALF_WIDTH-1:0] half_cnt_r;
  reg sck_lvl_r;
  reg phase_r;
  reg sck_in_q_r;
  reg tick_q_r;
  wire [2:0] mode = serial_mode_control_r[`SSP_MODE_FLD_HI:`SSP_MODE_FLD_LO];
  wire enabled = serial_mode_control_r[`SSP_EN_BIT];
  wire spi_sel = ~serial_mode_control_r[`SSP_UART_BIT] & (mode <= `SSP_M_SLAVE);
  wire is_slave = spi_sel & (mode == `SSP_M_SLAVE);
  wire is_master = spi_sel & ~is_slave;
  wire pol = serial_format_control_r[`SSP_POL_BIT];
  wire edge_sel = serial_format_control_r[`SSP_EDGE_BIT];
  wire msb_first = serial_format_control_r[`SSP_ORDER_BIT];
  wire select_pin_enable = serial_format_control_r[`SSP_SELECT_PIN_ENABLE_BIT];
  wire idle_lvl = ~pol;
  wire cap_rise = (pol == edge_sel);
  wire acc = psel_i & penable_i & ~pready_o;
  wire wr = acc & pwrite_i;
  wire rd = acc & ~pwrite_i;
  wire wr_fmt = wr & (paddr_i == `SSP_ADDR_FMT) & spi_sel;
  wire wr_data = wr & (paddr_i == `SSP_ADDR_DATA) & spi_sel;
  wire wr_mode = wr & (paddr_i == `SSP_ADDR_MODE);
  wire [7:0] sh_data;
  wire sh_sdo;
  wire ss_active = ~select_pin_enable | ~slave_select_n_i;
  // Master clock ticks per selected source.
  reg [HALF_WIDTH-1:0] half_lim;
  reg src_tick;
  always @* begin
    half_lim = `SSP_HALF_DIV4;
    src_tick = 1'b1;
    case (mode)
      `SSP_M_DIV16: half_lim = `SSP_HALF_DIV16;
      `SSP_M_DIV64: half_lim = `SSP_HALF_DIV64;
      `SSP_M_SUB: begin
        half_lim = {HALF_WIDTH{1'b0}};
        src_tick = sub_tick_i & ~tick_q_r;
      end
      `SSP_M_TMR: begin
        half_lim = {HALF_WIDTH{1'b0}};
        src_tick = tmr_match_i & ~tick_q_r;
      end
      default: half_lim = `SSP_HALF_DIV4;
    endcase
  end
  wire half_tick = src_tick & (half_cnt_r == half_lim);
  // Edge events for both roles.
  wire sck_rise_in = sck_i & ~sck_in_q_r;
  wire sck_fall_in = ~sck_i & sck_in_q_r;
  wire sl_go = is_slave & enabled & ss_active;
  wire sl_cap = sl_go & (cap_rise ? sck_rise_in : sck_fall_in);
  wire sl_sft = sl_go & (cap_rise ? sck_fall_in : sck_rise_in);
  wire m_tick = is_master & enabled & busy_r & half_tick;
  wire m_cap = m_tick & ~phase_r;
  wire m_sft = m_tick & phase_r;
  wire cap_ev = m_cap | sl_cap;
  wire sft_ev = m_sft | sl_sft;
  wire last_bit = (bit_cnt_r == `SSP_BITS - 4'h1);
  wire done_ev = cap_ev & last_bit;
  wire incomplete = is_slave & enabled & select_pin_enable & slave_select_n_i & busy_r;
  wire load = wr_data & ~busy_r;
  ssp_shifter #(
    .WIDTH(8)
  ) u_shift (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .load_i(load),
    .load_data_i(pwdata_i[7:0]),
    .sample_i(cap_ev),
    .shift_i(sft_ev),
    .msb_first_i(msb_first),
    .sdi_i(sdi_i),
    .data_o(sh_data),
    .sdo_o(sh_sdo)
  );
  // ---------------------------------------------------------------
  // Control state.
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      serial_mode_control_r <= `SSP_MODE_RST;
      serial_format_control_r <= `SSP_FMT_RST;
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
      busy_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      half_cnt_r <= {HALF_WIDTH{1'b0}};
      sck_lvl_r <= 1'b1;
      phase_r <= 1'b0;
      sck_in_q_r <= 1'b0;
      tick_q_r <= 1'b0;
    end else if (ce_i) begin
      sck_in_q_r <= sck_i;
      tick_q_r <= (mode == `SSP_M_SUB) ? sub_tick_i : tmr_match_i;
      if (wr_mode) begin
        serial_mode_control_r <= pwdata_i[7:0];
      end
      if (wr_fmt) begin
        serial_format_control_r <= pwdata_i[7:0];
      end
      if (wr_data & busy_r) begin
        serial_format_control_r[`SSP_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
        irq_stat_r[1] <= 1'b1;
      end
      if (!busy_r) begin
        sck_lvl_r <= idle_lvl;
      end
      if (is_master & load & enabled) begin
        busy_r <= 1'b1;
        bit_cnt_r <= 4'h0;
        half_cnt_r <= {HALF_WIDTH{1'b0}};
        phase_r <= 1'b0;
      end else if (is_slave & load) begin
        bit_cnt_r <= 4'h0;
      end
      if (sl_cap & ~busy_r) begin
        busy_r <= 1'b1;
      end
      if (busy_r & is_master & src_tick) begin
        half_cnt_r <= half_tick ? {HALF_WIDTH{1'b0}} : half_cnt_r + 1'b1;
      end
      if (m_tick) begin
        sck_lvl_r <= ~sck_lvl_r;
        phase_r <= ~phase_r;
      end
      if (cap_ev) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (done_ev) begin
        busy_r <= m_cap ? 1'b1 : 1'b0;
        bit_cnt_r <= 4'h0;
        serial_format_control_r[`SSP_TRF_BIT] <= ~m_cap;
        irq_stat_r[0] <= irq_stat_r[0] | ~m_cap;
      end
      if (m_sft & (bit_cnt_r == 4'h0) & ~phase_r) begin
        busy_r <= busy_r;
      end
      if (m_sft & bit_cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        serial_format_control_r[`SSP_TRF_BIT] <= 1'b1;
        irq_stat_r[0] <= 1'b1;
      end
      if (incomplete) begin
        busy_r <= 1'b0;
        bit_cnt_r <= 4'h0;
        serial_mode_control_r[`SSP_INCF_BIT] <= 1'b1;
        serial_format_control_r[`SSP_TRF_BIT] <= 1'b1;
        irq_stat_r[0] <= 1'b1;
      end
      if (rd & (paddr_i == `SSP_ADDR_IRQ_STAT)) begin
        irq_stat_r <= 2'h0;
      end
      if (wr & (paddr_i == `SSP_ADDR_IRQ_MASK)) begin
        irq_mask_r <= pwdata_i[1:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // Bus answer and pins.
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
      sck_o <= 1'b1;
      sck_oe_o <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      slave_select_n_o <= 1'b1;
      slave_select_n_oe_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= acc;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
      if (rd) begin
        case (paddr_i)
          `SSP_ADDR_MODE: prdata_o <= {24'h0, serial_mode_control_r};
          `SSP_ADDR_FMT: prdata_o <= spi_sel ? {24'h0, serial_format_control_r} : 32'h0;
          `SSP_ADDR_DATA: prdata_o <= spi_sel ? {24'h0, sh_data} : 32'h0;
          `SSP_ADDR_IRQ_STAT: prdata_o <= {30'h0, irq_stat_r};
          `SSP_ADDR_IRQ_MASK: prdata_o <= {30'h0, irq_mask_r};
          default: pslverr_o <= 1'b1;
        endcase
      end else if (wr) begin
        case (paddr_i)
          `SSP_ADDR_MODE, `SSP_ADDR_FMT, `SSP_ADDR_DATA: pslverr_o <= 1'b0;
          `SSP_ADDR_IRQ_STAT, `SSP_ADDR_IRQ_MASK: pslverr_o <= 1'b0;
          default: pslverr_o <= 1'b1;
        endcase
      end
      irq_o <= |(irq_stat_r & irq_mask_r);
      sck_o <= sck_lvl_r;
      sck_oe_o <= is_master & enabled;
      sdo_o <= sh_sdo;
      sdo_oe_o <= enabled & (is_master | (is_slave & ss_active));
      slave_select_n_o <= ~busy_r;
      slave_select_n_oe_o <= is_master & enabled & select_pin_enable;
    end
  end
endmodule

// ===== tb/ssp_top_sva.sv
module ssp_top_sva (
  input wire clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire sck_o,
  input wire sck_oe_o,
  input wire sdo_oe_o,
  input wire slave_select_n_o,
  input wire slave_select_n_oe_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic sck_q, sel_q;
  logic [4:0] tog_q;
  // ----------
  // Clock edges seen while the select line is low.
  // ----------
  always_ff @(posedge clk_i) begin
    sck_q <= sck_o;
    sel_q <= slave_select_n_o;
    if (slave_select_n_o && sel_q) tog_q <= 5'h00;
    else if (sck_o != sck_q) tog_q <= tog_q + 5'h01;
  end
  sequence frame_open;
    $fell(slave_select_n_o) && slave_select_n_oe_o;
  endsequence
  sequence clock_moves;
    ##[1:300] $changed(sck_o);
  endsequence
  chk_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("bus answer missing");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_reset_idle: assert property ($fell(reset_i) |-> !irq_o && !sck_oe_o && slave_select_n_o)
    else $error("outputs not idle after reset");
  chk_sel_master: assert property (slave_select_n_oe_o |-> sck_oe_o)
    else $error("select driven outside master");
  chk_sdo_master: assert property (sck_oe_o |-> sdo_oe_o)
    else $error("master not driving data");
  chk_frame_clock: assert property (frame_open |-> clock_moves)
    else $error("no clock after select");
  chk_bit_count: assert property ($rose(slave_select_n_o) && slave_select_n_oe_o |->
    tog_q inside {5'h0f, 5'h10})
    else $error("wrong clock edge count");
endmodule

// ===== tb/ssp_slave_model.sv
module ssp_slave_model (
  input wire sck_i,
  input wire mosi_i,
  input wire select_n_i,
  input wire [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic last = 1'b0;
  // ----------
  // Slave shifts only on the master clock while selected.
  // ----------
  always @(negedge select_n_i) sh = tx_i;
  always @(posedge sck_i) if (!select_n_i) rx_o = {rx_o[6:0], mosi_i};
  always @(negedge sck_i) if (!select_n_i) sh = {sh[6:0], 1'b0};
  always @* begin
    if (!select_n_i) last = sh[7];
    miso_o = select_n_i ? ~last : sh[7];
  end
endmodule

// ===== tb/shared_serial_spi_port_test.sv
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module shared_serial_spi_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic x;} ssp_row_t;
  logic clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, miso, sel_n, sel_oe, irq_o, err;
  logic [7:0] rd, tx, rx, got;
  logic m_sck = 1'b0, m_ssn = 1'b1, m_mosi = 1'b0, m_on = 1'b0;
  wire sdi_line = m_on ? m_mosi : miso;
  int mismatches = 0, total_checks = 0;
  wire sck_line = sck_oe_o ? sck_o : 1'b0;
  wire sel_line = sel_oe ? sel_n : 1'b1;
  ssp_row_t rows [10] = '{'{1'b0, 12'h000, 8'h00, 8'he0, 1'b0}, '{1'b0, 12'h004, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h004, 8'h3c, 8'h00, 1'b0}, '{1'b0, 12'h004, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h000, 8'h12, 8'h00, 1'b0}, '{1'b1, 12'h004, 8'h3c, 8'h00, 1'b0},
    '{1'b0, 12'h004, 8'h00, 8'h00, 1'b0}, '{1'b0, 12'h014, 8'h00, 8'h00, 1'b1},
    '{1'b0, 12'h010, 8'h00, 8'h00, 1'b0}, '{1'b0, 12'h00c, 8'h00, 8'h00, 1'b0}};
  ssp_top u_ssp_top (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sub_tick_i(1'b0),
    .tmr_match_i(1'b0), .sck_i(m_sck), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi_line),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .slave_select_n_i(m_ssn), .slave_select_n_o(sel_n),
    .slave_select_n_oe_o(sel_oe), .irq_o(irq_o));
  ssp_slave_model u_ssp_slave_model (.sck_i(sck_line), .mosi_i(sdo_o), .select_n_i(sel_line),
    .tx_i(tx), .miso_o(miso), .rx_o(rx));
  always #5 clk_i = ~clk_i;
  // ----------
  // Bus cycles and transfers.
  // ----------
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) mismatches++;
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic xfer(input logic [7:0] f, d, t, exp_rd, exp_rx);
    int n;
    apb(1'b1, 12'h004, f);
    tx = t;
    apb(1'b1, 12'h008, d);
    apb(1'b1, 12'h008, ~d);
    n = 0;
    do begin
      apb(1'b0, 12'h004, 8'h00);
      n++;
    end while (rd[0] !== 1'b1 && n < 60);
    `CHK(rd, f | 8'h03)
    `CHK(rx, exp_rx)
    apb(1'b0, 12'h008, 8'h00);
    `CHK(rd, exp_rd)
    apb(1'b1, 12'h004, f);
  endtask
  task automatic slv(input logic [7:0] d, input int n);
    m_ssn <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      m_mosi <= d[7 - i];
      repeat (4) @(posedge clk_i);
      got = {got[6:0], sdo_o};
      m_sck <= 1'b1;
      repeat (4) @(posedge clk_i);
      m_sck <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    m_ssn <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK(err, rows[i].x)
      if (!rows[i].w) `CHK(rd, rows[i].e)
    end
    apb(1'b1, 12'h000, 8'h02);
    apb(1'b1, 12'h004, 8'h3c);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h000, {k[2:0], 5'h02});
      apb(1'b0, 12'h004, 8'h00);
      `CHK(rd, (k < 6) ? 8'h3c : 8'h00)
    end
    apb(1'b1, 12'h000, 8'h02);
    xfer(8'h3c, 8'ha5, 8'h0f, 8'h0f, 8'ha5);
    `CHK(irq_o, 1'b0)
    apb(1'b1, 12'h010, 8'h03);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    apb(1'b0, 12'h00c, 8'h00);
    `CHK(rd, 8'h03)
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    xfer(8'h34, 8'h01, 8'h0f, 8'hf0, 8'h80);
    m_on <= 1'b1;
    apb(1'b1, 12'h000, 8'ha2);
    apb(1'b1, 12'h004, 8'h3c);
    apb(1'b1, 12'h008, 8'ha5);
    slv(8'h3c, 8);
    `CHK(got, 8'ha5)
    `CHK(sdo_oe_o, 1'b0)
    apb(1'b0, 12'h008, 8'h00);
    `CHK(rd, 8'h3c)
    apb(1'b0, 12'h004, 8'h00);
    `CHK(rd, 8'h3d)
    slv(8'h00, 3);
    apb(1'b0, 12'h000, 8'h00);
    `CHK(rd, 8'ha3)
    conclude();
  end
endmodule
bind ssp_top ssp_top_sva u_ssp_top_sva (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_oe_o(sdo_oe_o), .slave_select_n_o(slave_select_n_o),
  .slave_select_n_oe_o(slave_select_n_oe_o), .irq_o(irq_o));
